// [design/tsl_pkg.sv]
/*
 * Constants, field layout and carrier types for the temperature sensor
 * threshold and nonvolatile register bank.
 * Assumes a 125 MHz core clock and a serial-bus engine that hands over
 * one register access at a time.
 */
package tsl_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned TICK_US = 500;
    localparam int unsigned TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned SRST_MS = 2;
    localparam int unsigned SRST_CYCLES = SRST_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned NVM_PROG_CYCLES = 16;
    localparam int unsigned CONV_SAMPLE_US = 15500;
    localparam int unsigned CYCLE_US [8] = '{15500, 125000, 250000, 500000,
        1000000, 4000000, 8000000, 16000000};
    localparam int unsigned AVG_MIN_US [4] = '{0, 125000, 500000, 1000000};
    localparam int unsigned AVG_SAMPLES [4] = '{1, 8, 32, 64};

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONFIG = 8'h01;
    localparam logic [7:0] ADDR_UPPER = 8'h02;
    localparam logic [7:0] ADDR_LOWER = 8'h03;
    localparam logic [7:0] ADDR_UNLOCK = 8'h04;
    localparam logic [7:0] ADDR_SCRATCH1 = 8'h05;
    localparam logic [7:0] ADDR_SCRATCH2 = 8'h06;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned CFG_HIGH_BIT = 15;
    localparam int unsigned CFG_LOW_BIT = 14;
    localparam int unsigned CFG_DRDY_BIT = 13;
    localparam int unsigned CFG_BUSY_BIT = 12;
    localparam int unsigned CFG_MOD_LSB = 10;
    localparam int unsigned CFG_CONV_LSB = 7;
    localparam int unsigned CFG_AVG_LSB = 5;
    localparam int unsigned CFG_THERM_BIT = 4;
    localparam int unsigned CFG_SRST_BIT = 1;
    localparam int unsigned UNL_EN_BIT = 15;
    localparam int unsigned UNL_BUSY_BIT = 14;

    // ------------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------------
    localparam logic [15:0] CFG_RESET = 16'h0220;
    localparam logic [15:0] CFG_RW_MASK = 16'h0FFC;
    localparam logic [15:0] CFG_NV_MASK = 16'h07FC;
    localparam logic [15:0] UPPER_RESET = 16'h6000;
    localparam logic [15:0] LOWER_RESET = 16'h8000;
    localparam logic [15:0] SCRATCH2_RESET = 16'h0000;
    localparam logic UNLOCK_RESET = 1'b0;

    // Nonvolatile cell indices
    localparam int unsigned NVM_ENTRIES = 5;
    localparam logic [2:0] NV_CFG = 3'h0;
    localparam logic [2:0] NV_UPPER = 3'h1;
    localparam logic [2:0] NV_LOWER = 3'h2;
    localparam logic [2:0] NV_SCR1 = 3'h3;
    localparam logic [2:0] NV_SCR2 = 3'h4;

    // Conversion mode codes
    localparam logic [1:0] MODE_SD = 2'h1;
    localparam logic [1:0] MODE_CC_ALT = 2'h2;
    localparam logic [1:0] MODE_OS = 2'h3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } tsl_req_s;

    typedef enum {NVM_IDLE, NVM_LOAD, NVM_PROG} tsl_nvm_e;

endpackage

// [design/tsl_regs.sv]
/*
 * Register bank of the temperature sensor: configuration, thresholds,
 * nonvolatile unlock, scratch words, conversion pacing and soft reset.
 * Assumes the bus engine on clk_in presents one access per request and
 * the converter returns results with a one-cycle valid pulse.
 */
`timescale 1ns/1ns

// Notes on behaviour
// RULE1: Writing one to the soft reset bit starts a 2 ms internal reset.
// RULE2: The soft reset bit always reads back as zero.
// RULE3: Cycle code picks 15.5 ms up to 16 s when averaging is off.
// RULE4: Averaging 8, 32, 64 forces at least 125 ms, 500 ms, 1 s.
// RULE5: Averaging longer than the cycle leaves no standby between cycles.
// RULE6: Both thresholds are 16-bit, 7.8125 m C per step, +-256 C.
// RULE7: Thresholds compare as signed two's complement against results.
// RULE8: Upper threshold reloads from its cell at power-up or general call.
// RULE9: Lower threshold reloads from its cell at power-up or reset.
// RULE10: With unlock clear, writes touch only the volatile register.
// RULE11: With unlock set, a programmable write also programs its cell.
// RULE12: Unlock register bit 14 mirrors configuration busy bit 12.
// RULE13: Busy reads one during programming or reload, else zero.
// RULE14: First scratch word is read/write and reloads from its own cell.
// RULE15: First scratch cell holds a factory identifier the host may overwrite.
// RULE16: Host should leave the first scratch cell unprogrammed.
// RULE17: Second scratch word behaves like the first, factory value zero.
// RULE18: Alert mode upper flag sets above threshold, clears on config read.
// RULE19: Averaging code 00 none, 01 eight, 10 thirty-two, 11 sixty-four.
// RULE20: Host waits for busy low before another programming write.
// RULE21: Unused configuration and unlock bits read zero, ignore writes.
module tsl_regs
    import tsl_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES,
    parameter int unsigned SRST_LEN = SRST_CYCLES,
    parameter int unsigned PROG_LEN = NVM_PROG_CYCLES,
    parameter logic [15:0] FACTORY_UID = 16'h5A3C // Arbitrary value
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire tsl_req_s req_in,
    input wire logic gcall_reset_in,
    input wire logic [15:0] result_in,
    input wire logic result_valid_in,
    output logic [15:0] rdata_out,
    output logic rvalid_out,
    output logic conv_start_out,
    output logic [1:0] averaging_select_out,
    output logic high_alert_out,
    output logic low_alert_out,
    output logic data_ready_out,
    output logic nvm_busy_out,
    output logic soft_reset_out
);

    localparam int unsigned TW = $clog2(TICK_LEN + 1);
    localparam int unsigned SW = $clog2(SRST_LEN + 1);
    localparam int unsigned PW = $clog2(PROG_LEN + 1);
    localparam logic [15:0] NV_FACTORY [NVM_ENTRIES] = '{CFG_RESET,
        UPPER_RESET, LOWER_RESET, FACTORY_UID, SCRATCH2_RESET};

    // Every check samples on the rising clock, off while in reset
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    // ------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------
    logic wr_cfg, rd_cfg, srst_trig, nv_hit;
    logic [2:0] nv_idx;

    // Map a bus address onto its nonvolatile cell
    always_comb begin
        nv_hit = 1'b1;
        nv_idx = NV_CFG;
        case (req_in.addr)
            ADDR_CONFIG: nv_idx = NV_CFG;
            ADDR_UPPER: nv_idx = NV_UPPER;
            ADDR_LOWER: nv_idx = NV_LOWER;
            ADDR_SCRATCH1: nv_idx = NV_SCR1;
            ADDR_SCRATCH2: nv_idx = NV_SCR2;
            default: nv_hit = 1'b0;
        endcase
    end

    assign wr_cfg = req_in.wr && req_in.addr == ADDR_CONFIG;
    assign rd_cfg = req_in.rd && req_in.addr == ADDR_CONFIG;
    assign srst_trig = wr_cfg && req_in.wdata[CFG_SRST_BIT]; // RULE1

    // ------------------------------------------------------------------
    // Nonvolatile cells, reload and programming
    // ------------------------------------------------------------------
    tsl_nvm_e nvm_state_reg, nvm_state_next;
    logic [2:0] nvm_idx_reg, nvm_idx_next;
    logic [PW-1:0] prog_cnt_reg, prog_cnt_next;
    logic [15:0] prog_data_reg, prog_data_next;
    logic [15:0] nvm_cell_reg [NVM_ENTRIES];
    logic [15:0] nvm_cell_next [NVM_ENTRIES];
    logic unlock_reg, unlock_next;
    logic load_en;

    assign load_en = nvm_state_reg == NVM_LOAD;

    // Sequencer: reload walks every cell, programming waits out its time
    always_comb begin
        nvm_state_next = nvm_state_reg;
        nvm_idx_next = nvm_idx_reg;
        prog_cnt_next = prog_cnt_reg;
        prog_data_next = prog_data_reg;
        nvm_cell_next = nvm_cell_reg;
        case (nvm_state_reg)
            NVM_IDLE: begin
                if (req_in.wr && nv_hit && unlock_reg && !srst_trig) begin
                    nvm_state_next = NVM_PROG; // RULE11
                    nvm_idx_next = nv_idx;
                    prog_cnt_next = PW'(PROG_LEN);
                    prog_data_next = req_in.wdata;
                end
            end
            NVM_LOAD: begin
                if (nvm_idx_reg == 3'(NVM_ENTRIES - 1)) begin
                    nvm_state_next = NVM_IDLE;
                end else begin
                    nvm_idx_next = nvm_idx_reg + 3'h1;
                end
            end
            NVM_PROG: begin
                prog_cnt_next = prog_cnt_reg - PW'(1);
                if (prog_cnt_reg == PW'(1)) begin
                    nvm_cell_next[nvm_idx_reg] = prog_data_reg; // RULE15
                    nvm_state_next = NVM_IDLE;
                end
            end
            default: nvm_state_next = NVM_IDLE;
        endcase
        if (gcall_reset_in || (srst_trig && nvm_state_reg != NVM_PROG)) begin
            nvm_state_next = NVM_LOAD; // RULE8 RULE9
            nvm_idx_next = NV_CFG;
        end
    end

    // Power-up starts with a reload of every cell
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            nvm_state_reg <= NVM_LOAD;
            nvm_idx_reg <= NV_CFG;
            prog_cnt_reg <= '0;
            prog_data_reg <= '0;
            nvm_cell_reg <= NV_FACTORY;
        end else begin
            nvm_state_reg <= nvm_state_next;
            nvm_idx_reg <= nvm_idx_next;
            prog_cnt_reg <= prog_cnt_next;
            prog_data_reg <= prog_data_next;
            nvm_cell_reg <= nvm_cell_next;
        end
    end

    assign nvm_busy_out = nvm_state_reg != NVM_IDLE; // RULE13

    // ------------------------------------------------------------------
    // Volatile registers and read port
    // ------------------------------------------------------------------
    logic [15:0] cfg_reg, cfg_next, upper_reg, upper_next;
    logic [15:0] lower_reg, lower_next, scr1_reg, scr1_next;
    logic [15:0] scr2_reg, scr2_next, rdata_next;
    logic high_reg, high_next, low_reg, low_next, drdy_reg, drdy_next;
    logic rvalid_next, above, below, therm;

    assign therm = cfg_reg[CFG_THERM_BIT];
    assign above = $signed(result_in) > $signed(upper_reg); // RULE6 RULE7
    assign below = $signed(result_in) < $signed(lower_reg); // RULE7

    // Reload first, host write on top, flags with set over clear
    always_comb begin
        cfg_next = cfg_reg;
        upper_next = upper_reg;
        lower_next = lower_reg;
        scr1_next = scr1_reg;
        scr2_next = scr2_reg;
        unlock_next = unlock_reg;
        if (load_en) begin
            case (nvm_idx_reg)
                NV_CFG: cfg_next = nvm_cell_reg[NV_CFG] & CFG_NV_MASK;
                NV_UPPER: upper_next = nvm_cell_reg[NV_UPPER]; // RULE8
                NV_LOWER: lower_next = nvm_cell_reg[NV_LOWER]; // RULE9
                NV_SCR1: scr1_next = nvm_cell_reg[NV_SCR1]; // RULE14
                NV_SCR2: scr2_next = nvm_cell_reg[NV_SCR2]; // RULE17
                default: cfg_next = cfg_reg;
            endcase
        end
        if (req_in.wr && !srst_trig) begin
            case (req_in.addr)
                ADDR_CONFIG: begin
                    cfg_next = req_in.wdata & CFG_RW_MASK; // RULE21
                    if (cfg_next[CFG_MOD_LSB+:2] == MODE_CC_ALT) begin
                        cfg_next[CFG_MOD_LSB+:2] = 2'h0;
                    end
                end
                ADDR_UPPER: upper_next = req_in.wdata; // RULE10
                ADDR_LOWER: lower_next = req_in.wdata; // RULE10
                ADDR_UNLOCK: unlock_next = req_in.wdata[UNL_EN_BIT];
                ADDR_SCRATCH1: scr1_next = req_in.wdata; // RULE14
                ADDR_SCRATCH2: scr2_next = req_in.wdata; // RULE17
                default: unlock_next = unlock_reg;
            endcase
        end
        if (conv_start_out && cfg_reg[CFG_MOD_LSB+:2] == MODE_OS) begin
            cfg_next[CFG_MOD_LSB+:2] = MODE_SD;
        end
        if (srst_trig) begin
            unlock_next = UNLOCK_RESET;
        end
        high_next = high_reg && !rd_cfg; // RULE18
        low_next = low_reg && !rd_cfg;
        drdy_next = (drdy_reg && !rd_cfg) || result_valid_in;
        if (result_valid_in) begin
            if (therm) begin
                high_next = above || (high_reg && !below);
                low_next = 1'b0;
            end else begin
                high_next = high_next || above; // RULE18
                low_next = low_next || below;
            end
        end
        rvalid_next = req_in.rd;
        case (req_in.addr)
            ADDR_CONFIG: rdata_next = {high_reg, low_reg, drdy_reg,
                nvm_busy_out, cfg_reg[11:0]}; // RULE2 RULE21
            ADDR_UPPER: rdata_next = upper_reg;
            ADDR_LOWER: rdata_next = lower_reg;
            ADDR_UNLOCK: rdata_next = {unlock_reg, nvm_busy_out,
                14'h0000}; // RULE12 RULE21
            ADDR_SCRATCH1: rdata_next = scr1_reg;
            ADDR_SCRATCH2: rdata_next = scr2_reg;
            default: rdata_next = 16'h0000;
        endcase
        if (!req_in.rd) begin
            rdata_next = rdata_out;
        end
    end

    // Volatile registers hold factory values until the reload lands
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_reg <= CFG_RESET;
            upper_reg <= UPPER_RESET;
            lower_reg <= LOWER_RESET;
            scr1_reg <= FACTORY_UID;
            scr2_reg <= SCRATCH2_RESET;
            unlock_reg <= UNLOCK_RESET;
            high_reg <= 1'b0;
            low_reg <= 1'b0;
            drdy_reg <= 1'b0;
            rdata_out <= 16'h0000;
            rvalid_out <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            upper_reg <= upper_next;
            lower_reg <= lower_next;
            scr1_reg <= scr1_next;
            scr2_reg <= scr2_next;
            unlock_reg <= unlock_next;
            high_reg <= high_next;
            low_reg <= low_next;
            drdy_reg <= drdy_next;
            rdata_out <= rdata_next;
            rvalid_out <= rvalid_next;
        end
    end

    assign high_alert_out = high_reg;
    assign low_alert_out = low_reg;
    assign data_ready_out = drdy_reg;
    assign averaging_select_out = cfg_reg[CFG_AVG_LSB+:2]; // RULE19

    // ------------------------------------------------------------------
    // Conversion pacing and soft reset
    // ------------------------------------------------------------------
    logic [TW-1:0] tick_cnt_reg, tick_cnt_next;
    logic [15:0] per_cnt_reg, per_cnt_next, period_ticks;
    logic [15:0] cyc_ticks, avg_ticks, busy_ticks;
    logic [SW-1:0] srst_cnt_reg, srst_cnt_next;
    logic tick, conv_next, running;
    logic [2:0] conv_sel;
    logic [1:0] avg_sel, mode;

    assign conv_sel = cfg_reg[CFG_CONV_LSB+:3];
    assign avg_sel = cfg_reg[CFG_AVG_LSB+:2];
    assign mode = cfg_reg[CFG_MOD_LSB+:2];
    assign tick = tick_cnt_reg == TW'(TICK_LEN - 1);
    assign running = mode != MODE_SD && !soft_reset_out;
    assign soft_reset_out = srst_cnt_reg != '0;

    // Cycle period is the longest of table, averaging floor, sampling time
    always_comb begin
        cyc_ticks = 16'(CYCLE_US[conv_sel] / TICK_US); // RULE3
        avg_ticks = 16'(AVG_MIN_US[avg_sel] / TICK_US); // RULE4
        busy_ticks = 16'(AVG_SAMPLES[avg_sel] * CONV_SAMPLE_US
            / TICK_US); // RULE19
        period_ticks = cyc_ticks;
        if (avg_ticks > period_ticks) begin
            period_ticks = avg_ticks; // RULE4
        end
        if (busy_ticks > period_ticks) begin
            period_ticks = busy_ticks; // RULE5
        end
    end

    // Tick divider, period counter and soft reset timer
    always_comb begin
        tick_cnt_next = tick ? '0 : tick_cnt_reg + TW'(1);
        per_cnt_next = per_cnt_reg;
        conv_next = 1'b0;
        if (!running) begin
            per_cnt_next = 16'h0000;
        end else if (tick) begin
            if (per_cnt_reg == 16'h0000) begin
                conv_next = 1'b1;
            end
            per_cnt_next = per_cnt_reg + 16'h0001;
            if (per_cnt_next >= period_ticks) begin
                per_cnt_next = 16'h0000; // RULE5
            end
        end
        srst_cnt_next = soft_reset_out ? srst_cnt_reg - SW'(1) : '0;
        if (srst_trig && !soft_reset_out) begin
            srst_cnt_next = SW'(SRST_LEN); // RULE1
        end
    end

    // Pacing registers
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tick_cnt_reg <= '0;
            per_cnt_reg <= 16'h0000;
            srst_cnt_reg <= '0;
            conv_start_out <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            per_cnt_reg <= per_cnt_next;
            srst_cnt_reg <= srst_cnt_next;
            conv_start_out <= conv_next;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_srst_length: assert property ( // RULE1
        srst_trig && !soft_reset_out |=> soft_reset_out
            && srst_cnt_reg == SW'(SRST_LEN))
        else $error("soft reset did not start its full count");
    chk_srst_readzero: assert property ( // RULE2
        rd_cfg |=> rvalid_out && !rdata_out[CFG_SRST_BIT])
        else $error("soft reset bit read back as one");
    chk_period_table: assert property ( // RULE3
        avg_sel == 2'h0 && conv_sel != 3'h0 |-> period_ticks == cyc_ticks)
        else $error("cycle period differs from cycle code");
    // Floors in half-millisecond ticks: 125 ms, 500 ms, 1 s
    chk_avg_floor: assert property ( // RULE4
        (avg_sel != 2'h1 || period_ticks >= 16'h00FA)
            && (avg_sel != 2'h2 || period_ticks >= 16'h03E8)
            && (avg_sel != 2'h3 || period_ticks >= 16'h07D0))
        else $error("cycle period below averaging floor");
    chk_no_standby: assert property ( // RULE5
        running && tick && per_cnt_reg == period_ticks - 16'h0001
            |=> per_cnt_reg == 16'h0000)
        else $error("cycle did not restart at period end");
    chk_upper_signed: assert property ( // RULE7
        result_valid_in && $signed(result_in) > $signed(upper_reg)
            |=> high_alert_out)
        else $error("upper flag missed a signed crossing");
    chk_lock_volatile: assert property ( // RULE10
        nvm_state_reg == NVM_IDLE && req_in.wr && !unlock_reg
            && !gcall_reset_in && !srst_trig |=> nvm_state_reg == NVM_IDLE)
        else $error("locked write started programming");
    chk_unlock_prog: assert property ( // RULE11
        nvm_state_reg == NVM_IDLE && req_in.wr && nv_hit && unlock_reg
            && !gcall_reset_in && !srst_trig
            |=> nvm_state_reg == NVM_PROG ##0 nvm_busy_out [*2])
        else $error("unlocked write did not program its cell");
    chk_busy_mirror: assert property ( // RULE12
        req_in.rd && req_in.addr == ADDR_UNLOCK
            |=> rdata_out[UNL_BUSY_BIT] == $past(nvm_busy_out))
        else $error("unlock busy bit does not mirror busy flag");
    chk_alert_clear: assert property ( // RULE18
        rd_cfg && !therm && !result_valid_in |=> !high_alert_out)
        else $error("upper flag survived a configuration read");

endmodule // tsl_regs

// [bench/tsl_host.sv]
/*
 * Host model: issues one register access at a time on req_out.
 * Assumes the bank answers reads with a one-cycle rvalid pulse.
 */
`timescale 1ns/1ns
module tsl_host
    import tsl_pkg::*;
(
    input wire logic clk_in,
    input wire logic [15:0] rdata_in,
    input wire logic rvalid_in,
    input wire logic busy_in,
    output tsl_req_s req_out
);
    initial req_out = '0;
    int n_timeouts = 0; // Busy waits that ran out

    // Write one word, waiting first for an idle memory
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        int k;
        @(negedge clk_in);
        for (k = 0; k < 100 && busy_in !== 1'b0; k++) begin
            @(negedge clk_in);
        end
        if (k == 100) n_timeouts++;
        req_out = '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(negedge clk_in);
        req_out = '0;
    endtask

    // Read one word; unknown if no answer comes
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        int k;
        @(negedge clk_in);
        req_out = '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(negedge clk_in);
        req_out = '0;
        for (k = 0; k < 4 && rvalid_in !== 1'b1; k++) @(negedge clk_in);
        v = (rvalid_in === 1'b1) ? rdata_in : 16'hxxxx;
    endtask
endmodule // tsl_host

// [bench/tsl_regs_tb.sv]
/*
 * Self-checking bench for the register bank against an array model.
 * Assumes shortened tick, soft reset and programming counts.
 */
`timescale 1ns/1ns
module tsl_regs_tb;
    import tsl_pkg::*;
    localparam logic [15:0] UID = 16'h5A3C; // Arbitrary value
    logic clk_in = 0, resetn_in = 0, gcall_reset_in = 0;
    logic result_valid_in = 0, rvalid_out, conv_start_out, high_alert_out;
    logic low_alert_out, data_ready_out, nvm_busy_out, soft_reset_out;
    logic [15:0] result_in = 16'h0000, rdata_out, d, x;
    logic [1:0] averaging_select_out;
    tsl_req_s req_in;
    int n_errors = 0, comparisons = 0, seed = 62, a, n;
    int fl [4] = '{31, 250, 1000, 2000};
    int sm [4] = '{1, 8, 32, 64};
    logic [15:0] m [8]; // Volatile registers
    logic [15:0] c [8]; // Nonvolatile cells

    always #4 clk_in = ~clk_in;

    tsl_regs #(.TICK_LEN(4), .SRST_LEN(20), .PROG_LEN(3),
        .FACTORY_UID(UID)) dut (.clk_in(clk_in), .resetn_in(resetn_in),
        .req_in(req_in), .gcall_reset_in(gcall_reset_in),
        .result_in(result_in), .result_valid_in(result_valid_in),
        .rdata_out(rdata_out), .rvalid_out(rvalid_out),
        .conv_start_out(conv_start_out),
        .averaging_select_out(averaging_select_out),
        .high_alert_out(high_alert_out), .low_alert_out(low_alert_out),
        .data_ready_out(data_ready_out), .nvm_busy_out(nvm_busy_out),
        .soft_reset_out(soft_reset_out));
    tsl_host host (.clk_in(clk_in), .rdata_in(rdata_out),
        .rvalid_in(rvalid_out), .busy_in(nvm_busy_out), .req_out(req_in));

    // Compare, count, report
    task automatic check(string nm, logic [15:0] got, logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic complete_run;
        n_errors += host.n_timeouts;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic hang;
        n_errors++;
        complete_run;
    endtask
    task automatic rchk(input logic [7:0] r);
        host.rd(r, d);
        check("register", d, m[r]);
    endtask
    task automatic waitb;
        int k;
        for (k = 0; k < 60 && nvm_busy_out !== 1'b0; k++) @(negedge clk_in);
        if (k == 60) hang;
    endtask
    // General-call reload of volatile copies from cells
    task automatic gcall;
        gcall_reset_in = 1;
        @(negedge clk_in);
        gcall_reset_in = 0;
        @(negedge clk_in);
        waitb;
        for (int k = 2; k < 7; k++) if (k != 4) m[k] = c[k];
    endtask
    task automatic pulse(output int k);
        for (k = 0; k < 9000 && conv_start_out !== 1'b1; k++)
            @(negedge clk_in);
        if (k == 9000) hang;
    endtask
    task automatic flag(string nm, logic f, logic e);
        check(nm, {15'h0000, f}, {15'h0000, e});
    endtask

    // Main sequence
    initial begin
        m = '{default: 16'h0000};
        m[2] = 16'h6000;
        m[3] = 16'h8000;
        m[5] = UID;
        c = m;
        repeat (20) @(negedge clk_in);
        resetn_in = 1;
        waitb;
        for (a = 2; a < 7; a++) rchk(8'(a));
        $display("test reset values done");
        for (a = 2; a < 7; a++) if (a != 4) begin
            m[a] = 16'($random(seed));
            host.wr(8'(a), m[a]);
            rchk(8'(a));
        end
        host.wr(8'h09, 16'hFFFF);
        host.rd(8'h09, d);
        check("unmapped", d, 16'h0000);
        gcall;
        for (a = 2; a < 7; a++) rchk(8'(a));
        $display("test locked writes done");
        host.wr(8'h04, 16'hFFFF);
        m[4] = 16'h8000;
        rchk(8'h04);
        x = 16'($random(seed));
        host.wr(8'h06, x);
        flag("busy", nvm_busy_out, 1'b1);
        host.rd(8'h04, d);
        check("unlock busy", d, 16'hC000);
        waitb;
        host.wr(8'h04, 16'h0000);
        m[4] = 16'h0000;
        c[6] = x;
        gcall;
        rchk(8'h06);
        $display("test programming done");
        host.wr(8'h01, 16'h0002);
        for (n = 0; n < 100 && soft_reset_out === 1'b1; n++) @(negedge clk_in);
        check("soft reset len", 16'(n), 16'd20);
        waitb;
        host.rd(8'h01, d);
        check("config", d, 16'h0220);
        rchk(8'h04);
        $display("test soft reset done");
        for (a = 0; a < 4; a++) begin
            host.wr(8'h01, {9'h000, 2'(a), 5'h00});
            check("avg", {14'h0000, averaging_select_out}, 16'(a));
            pulse(n);
            @(negedge clk_in);
            pulse(n);
            n = (n + 1) / 4;
            check("cycle ticks", 16'(n), 16'(fl[a] > sm[a] * 31 ?
                fl[a] : sm[a] * 31));
        end
        $display("test pacing done");
        host.wr(8'h02, 16'h0100);
        host.wr(8'h03, 16'h0000);
        host.rd(8'h01, d);
        for (a = 0; a < 2; a++) begin
            result_in = a ? 16'hFF00 : 16'h0200;
            result_valid_in = 1;
            @(negedge clk_in);
            result_valid_in = 0;
            flag("high", high_alert_out, !a);
            flag("low", low_alert_out, a[0]);
            flag("ready", data_ready_out, 1'b1);
            host.rd(8'h01, d);
            @(negedge clk_in);
            flag("high clr", high_alert_out, 1'b0);
            flag("low clr", low_alert_out, 1'b0);
            flag("ready clr", data_ready_out, 1'b0);
        end
        $display("test alerts done");
        host.wr(8'h01, 16'h0811);
        host.rd(8'h01, d);
        check("mode fold", d, 16'h0010);
        for (a = 0; a < 3; a++) begin
            result_in = a == 0 ? 16'h0200 : a == 1 ? 16'h0080 : 16'hFF00;
            result_valid_in = 1;
            @(negedge clk_in);
            result_valid_in = 0;
            @(negedge clk_in);
            flag("therm high", high_alert_out, a < 2);
            flag("therm low", low_alert_out, 1'b0);
        end
        host.wr(8'h01, 16'h0C00);
        pulse(n);
        @(negedge clk_in);
        host.rd(8'h01, d);
        check("one shot", d, 16'h2400);
        $display("test modes done");
        complete_run;
    end
endmodule // tsl_regs_tb
